// *** core/spp_page_write.sv ***
// What this block does
// [RULE1] write refused unless arm latch set earlier
// [RULE2] host selects, sends opcode, address, data
// [RULE3] bytes past page end wrap to page start
// [RULE4] over 64 bytes: last 64 kept
// [RULE5] fewer bytes: other page bytes untouched
// [RULE6] host holds select low whole sequence
// [RULE7] execute only on whole final byte
// [RULE8] deselect after valid frame starts program cycle
// [RULE9] progress flag one during cycle, zero after
// [RULE10] arm latch cleared during program cycle
// [RULE11] busy: only status read accepted, rest ignored
// [RULE12] protected target page is never programmed
// [RULE13] two-line variant: two data bits per clock
// [RULE14] four-line variant: four data bits per clock
// [RULE15] four-line opcode disables shared pin functions
// [RULE16] two-line header still on line zero
// [RULE17] all write flavours behave the same
// [RULE18] host presets page to ones first
// [RULE19] host should batch consecutive bytes
// [RULE20] header bits sampled on rising serial clock
// [RULE21] msb first, higher bits on higher lines
`default_nettype none
module spp_page_write #(
  parameter logic [7:0] PAGE_WRITE_CMD = 8'h02,
  parameter logic [7:0] TWO_LINE_WRITE_CMD = 8'hA2,
  parameter logic [7:0] FOUR_LINE_WRITE_CMD = 8'h32,
  parameter logic [7:0] WRITE_ARM_CMD = 8'h06,
  parameter logic [7:0] STATUS_READ_CMD = 8'h05,
  parameter int PROG_TIME_US = 100,
  parameter int PROG_CYCLES = PROG_TIME_US * spp_pkg::CLK_FREQ_MHZ
) (
  // system clock domain
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  // serial link
  input wire logic sclk,
  input wire logic selectN,
  input wire logic [3:0] ioLine,
  // protection setting
  input wire logic [spp_pkg::GUARD_W-1:0] areaGuard,
  // status
  output logic writeInProgressFlag,
  output logic writeLatchFlag,
  output logic sharedPinsOff,
  output logic cmdRejected,
  // array write port
  output logic arrayWrite,
  output spp_pkg::spp_arr_type arrayReq
);

  localparam int TIMER_W = $clog2(PROG_CYCLES + 1);
  localparam logic [TIMER_W-1:0] TIMER_LOAD = TIMER_W'(PROG_CYCLES);
  localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(1);

  // ----------------------------------------
  // link domain: frame capture
  // ----------------------------------------
  logic linkRst;
  logic inFrame;
  logic frameTog;
  logic busyLink;
  logic [5:0] headCnt;
  logic [5:0] curHead;
  logic [7:0] opShift;
  logic [spp_pkg::ADDR_W-1:0] addrShift;
  logic [2:0] bitCnt;
  logic [2:0] lanes;
  logic [2:0] next_bitCnt;
  logic [6:0] byteCnt;
  logic [7:0] dataShift;
  logic [7:0] next_dataShift;
  logic [spp_pkg::PAGE_BITS-1:0] slot;
  logic [spp_pkg::PAGE_BITS-1:0] curSlot;
  logic [spp_pkg::PAGE_BYTES-1:0] mask;
  logic [7:0] pageBuf [spp_pkg::PAGE_BYTES];
  logic opIsWrite;
  logic byteDone;

  // leaving select high ends the frame and clears its framing state
  assign linkRst = rst | selectN; // RULE6

  always_ff @(posedge sclk or posedge linkRst) begin
    if (linkRst) begin
      inFrame <= 1'b0;
    end else begin
      inFrame <= 1'b1;
    end
  end

  // a toggle per frame, so a select pulse with no clock is not a new frame
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      frameTog <= 1'b0;
    end else if (!inFrame) begin
      frameTog <= ~frameTog;
    end
  end

  // busy seen from the link side, so a refused write cannot disturb the page
  spp_sync #(.W(1)) u_busy_sync (
    .clk(sclk),
    .rst(rst),
    .en(1'b1),
    .d(writeInProgressFlag),
    .q(busyLink)
  );

  assign curHead = inFrame ? headCnt : 6'h00;
  assign opIsWrite = (opShift == PAGE_WRITE_CMD) || (opShift == TWO_LINE_WRITE_CMD) ||
                     (opShift == FOUR_LINE_WRITE_CMD); // RULE17
  assign curSlot = (byteCnt == 7'h00) ? addrShift[spp_pkg::PAGE_BITS-1:0] : slot;

  always_comb begin
    if (opShift == FOUR_LINE_WRITE_CMD) begin
      lanes = spp_pkg::LANES_FOUR;
      next_dataShift = {dataShift[3:0], ioLine[3:0]}; // RULE14 RULE21
    end else if (opShift == TWO_LINE_WRITE_CMD) begin
      lanes = spp_pkg::LANES_TWO;
      next_dataShift = {dataShift[5:0], ioLine[1:0]}; // RULE13 RULE21
    end else begin
      lanes = spp_pkg::LANES_ONE;
      next_dataShift = {dataShift[6:0], ioLine[0]};
    end
    next_bitCnt = bitCnt + lanes;
  end

  assign byteDone = (curHead == spp_pkg::HEAD_BITS) && (next_bitCnt == 3'h0);

  // header: opcode then three address bytes, one bit a clock on line zero
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      headCnt <= 6'h00;
      opShift <= 8'h00;
      addrShift <= '0;
    end else if (curHead < spp_pkg::HEAD_BITS) begin // RULE2
      headCnt <= curHead + 6'h01;
      if (curHead < 6'(spp_pkg::OPCODE_BITS)) begin
        opShift <= {opShift[6:0], ioLine[0]}; // RULE16 RULE20 RULE21
      end else if (!busyLink) begin
        addrShift <= {addrShift[spp_pkg::ADDR_W-2:0], ioLine[0]}; // RULE16 RULE20
      end
    end
  end

  // data phase bit and byte counting
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      bitCnt <= 3'h0;
      byteCnt <= 7'h00;
      dataShift <= 8'h00;
    end else if (curHead < spp_pkg::HEAD_BITS) begin
      bitCnt <= 3'h0;
      byteCnt <= 7'h00;
    end else begin
      bitCnt <= next_bitCnt;
      dataShift <= next_dataShift;
      if (byteDone && byteCnt != spp_pkg::BYTE_CNT_MAX) begin
        byteCnt <= byteCnt + 7'h01;
      end
    end
  end

  // page buffer: the slot wraps inside the page, so later bytes overwrite earlier
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      slot <= '0;
      mask <= '0;
    end else if (byteDone && opIsWrite && !busyLink) begin
      slot <= curSlot + 6'h01; // RULE3 RULE4
      if (byteCnt == 7'h00) begin
        mask <= spp_pkg::PAGE_BYTES'(1) << curSlot; // RULE5
      end else begin
        mask[curSlot] <= 1'b1; // RULE5
      end
    end
  end

  always_ff @(posedge sclk) begin
    if (byteDone && opIsWrite && !busyLink) begin
      pageBuf[curSlot] <= next_dataShift; // RULE4
    end
  end

  // shared pin functions released for the rest of the frame
  always_ff @(posedge sclk or posedge linkRst) begin
    if (linkRst) begin
      sharedPinsOff <= 1'b0;
    end else if (curHead == spp_pkg::OPCODE_LAST &&
                 {opShift[6:0], ioLine[0]} == FOUR_LINE_WRITE_CMD) begin
      sharedPinsOff <= 1'b1; // RULE15
    end
  end

  // ----------------------------------------
  // system domain: end of frame decision
  // ----------------------------------------
  logic selSync;
  logic selPrev;
  logic deselect;
  logic seenTog;
  logic newFrame;
  logic prot;
  logic validWrite;
  logic validArm;
  logic startProg;
  logic [TIMER_W-1:0] timer;
  logic [6:0] walkIdx;
  spp_pkg::spp_state_type state;
  spp_pkg::spp_frame_type frame;

  // frame words are still while select is high, since the link clock stops
  assign frame.opcode = opShift;
  assign frame.addr = addrShift;
  assign frame.headBits = headCnt;
  assign frame.hasData = (byteCnt != 7'h00);
  assign frame.aligned = (bitCnt == 3'h0);

  spp_sync #(.W(1)) u_sel_sync (
    .clk(clk),
    .rst(rst),
    .en(clkEn),
    .d(selectN),
    .q(selSync)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      selPrev <= 1'b0;
      seenTog <= 1'b0;
    end else if (clkEn) begin
      selPrev <= selSync;
      if (deselect) begin
        seenTog <= frameTog;
      end
    end
  end

  assign deselect = selSync & ~selPrev;
  assign newFrame = deselect && (frameTog != seenTog);

  // guarded area sits at the top of the array and doubles with each step
  function automatic logic isProtected(input logic [spp_pkg::GUARD_W-1:0] g,
                                       input logic [spp_pkg::ADDR_W-1:0] a);
    logic [31:0] span;
    span = 32'h0;
    if (g == '0) begin
      return 1'b0;
    end
    span = 32'h1 << (spp_pkg::SECTOR_BITS + int'(g) - 1);
    return (span >= spp_pkg::ADDR_SPAN) || ({8'h00, a} >= spp_pkg::ADDR_SPAN - span);
  endfunction

  assign prot = isProtected(areaGuard, frame.addr);
  assign validWrite = (frame.opcode == PAGE_WRITE_CMD || frame.opcode == TWO_LINE_WRITE_CMD ||
                       frame.opcode == FOUR_LINE_WRITE_CMD) && // RULE17
                      frame.headBits == spp_pkg::HEAD_BITS && frame.hasData &&
                      frame.aligned && // RULE7
                      writeLatchFlag && // RULE1
                      !prot; // RULE12
  assign validArm = (frame.opcode == WRITE_ARM_CMD) && (frame.headBits == spp_pkg::ARM_BITS);
  assign startProg = newFrame && validWrite && (state == spp_pkg::ST_IDLE); // RULE8

  // program cycle: fixed duration, progress flag high throughout
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= spp_pkg::ST_IDLE;
      timer <= '0;
      writeInProgressFlag <= spp_pkg::FLAG_RESET;
    end else if (clkEn) begin
      unique case (state)
        spp_pkg::ST_IDLE: begin
          if (startProg) begin
            state <= spp_pkg::ST_PROG;
            timer <= TIMER_LOAD;
            writeInProgressFlag <= 1'b1; // RULE8 RULE9
          end
        end
        spp_pkg::ST_PROG: begin
          timer <= timer - TIMER_LAST;
          if (timer == TIMER_LAST) begin
            state <= spp_pkg::ST_IDLE;
            writeInProgressFlag <= 1'b0; // RULE9
          end
        end
      endcase
    end
  end

  // arm latch: set by the arm frame when idle, dropped as programming starts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      writeLatchFlag <= spp_pkg::FLAG_RESET;
    end else if (clkEn) begin
      if (startProg) begin
        writeLatchFlag <= 1'b0; // RULE10
      end else if (newFrame && validArm && state == spp_pkg::ST_IDLE) begin
        writeLatchFlag <= 1'b1; // RULE1
      end
    end
  end

  // anything but a status read while busy is dropped; flagged for visibility
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmdRejected <= 1'b0;
    end else if (clkEn) begin
      cmdRejected <= newFrame && (state == spp_pkg::ST_PROG) &&
                     (frame.opcode != STATUS_READ_CMD); // RULE11
    end
  end

  // walk the page once at the start of the cycle; only latched bytes are written
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      walkIdx <= 7'(spp_pkg::PAGE_BYTES);
      arrayWrite <= 1'b0;
      arrayReq <= '0;
    end else if (clkEn) begin
      arrayWrite <= 1'b0;
      if (startProg) begin
        walkIdx <= 7'h00;
      end else if (walkIdx < 7'(spp_pkg::PAGE_BYTES)) begin
        walkIdx <= walkIdx + 7'h01;
        arrayWrite <= mask[walkIdx[spp_pkg::PAGE_BITS-1:0]]; // RULE5
        arrayReq.addr <= {frame.addr[spp_pkg::ADDR_W-1:spp_pkg::PAGE_BITS],
                          walkIdx[spp_pkg::PAGE_BITS-1:0]}; // RULE3
        arrayReq.data <= pageBuf[walkIdx[spp_pkg::PAGE_BITS-1:0]];
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_arm_gate: assert property (@(posedge clk) disable iff (rst) // RULE1
    $rose(writeInProgressFlag) |-> $past(writeLatchFlag))
    else $error("program started without arm latch");

  chk_cycle_start: assert property (@(posedge clk) disable iff (rst) // RULE8
    (clkEn && startProg) |=> writeInProgressFlag && timer == TIMER_LOAD)
    else $error("valid frame did not start program cycle");

  chk_cycle_end: assert property (@(posedge clk) disable iff (rst) // RULE9
    $fell(writeInProgressFlag) |-> $past(timer) == TIMER_LAST && state == spp_pkg::ST_IDLE)
    else $error("progress flag dropped before full duration");

  chk_latch_clear: assert property (@(posedge clk) disable iff (rst) // RULE10
    writeInProgressFlag |-> !writeLatchFlag)
    else $error("arm latch still set during program cycle");

  chk_busy_ignore: assert property (@(posedge clk) disable iff (rst) // RULE11
    (clkEn && newFrame && state == spp_pkg::ST_PROG && timer > TIMER_LAST)
      |=> writeInProgressFlag && $stable(writeLatchFlag) && timer == $past(timer) - TIMER_LAST)
    else $error("command disturbed running program cycle");

  chk_protect_block: assert property (@(posedge clk) disable iff (rst) // RULE12
    (clkEn && newFrame && prot && state == spp_pkg::ST_IDLE) |=> !writeInProgressFlag)
    else $error("protected page programmed");

  chk_partial_byte: assert property (@(posedge clk) disable iff (rst) // RULE7
    (clkEn && newFrame && !frame.aligned && state == spp_pkg::ST_IDLE)
      |=> !writeInProgressFlag [*2])
    else $error("frame with partial byte executed");

  chk_page_wrap: assert property (@(posedge clk) disable iff (rst) // RULE3
    arrayWrite |-> writeInProgressFlag &&
      arrayReq.addr[spp_pkg::ADDR_W-1:spp_pkg::PAGE_BITS] ==
      frame.addr[spp_pkg::ADDR_W-1:spp_pkg::PAGE_BITS])
    else $error("array write left the addressed page");

  chk_byte_mask: assert property (@(posedge clk) disable iff (rst) // RULE5
    arrayWrite |-> mask[arrayReq.addr[spp_pkg::PAGE_BITS-1:0]])
    else $error("unlatched byte written to array");

  chk_quad_pins: assert property (@(posedge sclk) disable iff (linkRst) // RULE15
    (curHead == spp_pkg::OPCODE_LAST && {opShift[6:0], ioLine[0]} == FOUR_LINE_WRITE_CMD)
      |=> sharedPinsOff)
    else $error("shared pins not released after four-line opcode");

  cov_program: cover property (@(posedge clk) disable iff (rst)
    startProg ##1 writeInProgressFlag);
  cov_reject: cover property (@(posedge clk) disable iff (rst) cmdRejected);
  cov_wrap: cover property (@(posedge clk) disable iff (rst)
    arrayWrite && arrayReq.addr[spp_pkg::PAGE_BITS-1:0] == '0 &&
    frame.addr[spp_pkg::PAGE_BITS-1:0] != '0);
  cov_arm: cover property (@(posedge clk) disable iff (rst) $rose(writeLatchFlag));

endmodule
`default_nettype wire

// *** inc/spp_pkg.sv ***
`default_nettype none
package spp_pkg;

  // ----------------------------------------
  // address and page layout
  // ----------------------------------------
  localparam int ADDR_W = 24;
  localparam int PAGE_BITS = 6;
  localparam int PAGE_BYTES = 64;
  localparam int SECTOR_BITS = 14;
  localparam int GUARD_W = 4;
  localparam logic [31:0] ADDR_SPAN = 32'h0100_0000;

  // ----------------------------------------
  // frame framing
  // ----------------------------------------
  localparam int OPCODE_BITS = 8;
  localparam logic [5:0] HEAD_BITS = 6'h20;
  localparam logic [5:0] OPCODE_LAST = 6'h07;
  localparam logic [5:0] ARM_BITS = 6'h08;
  localparam logic [2:0] LANES_ONE = 3'h1;
  localparam logic [2:0] LANES_TWO = 3'h2;
  localparam logic [2:0] LANES_FOUR = 3'h4;
  localparam logic [6:0] BYTE_CNT_MAX = 7'h7F;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_FREQ_MHZ = 200;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic FLAG_RESET = 1'b0;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] opcode;
    logic [ADDR_W-1:0] addr;
    logic [5:0] headBits;
    logic hasData;
    logic aligned;
  } spp_frame_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } spp_arr_type;

  typedef enum logic {
    ST_IDLE,
    ST_PROG
  } spp_state_type;

endpackage
`default_nettype wire

// *** core/spp_sync.sv ***
`default_nettype none
// three-stage input catcher; the output moves once stages two and three agree
module spp_sync #(
  parameter int W = 1
) (
  // clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end else if (en) begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q <= s3;
      end
    end
  end

endmodule
`default_nettype wire

// *** bench/spp_host_model.sv ***
`default_nettype none
// host side of the serial link; the link clock idles low and only runs inside frames
module spp_host_model (
  // serial link
  output logic sclk,
  output logic selectN,
  output logic [3:0] ioLine
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclk = 1'b0;
    selectN = 1'b1;
    ioLine = 4'hA;
  end

  // ----------------------------------------
  // one link edge: drive while low, device samples on the rise
  // ----------------------------------------
  task automatic clock_bits(input logic [3:0] v);
    ioLine = v;
    #7.5;
    sclk = 1'b1;
    #7.5;
    sclk = 1'b0;
  endtask

  // ----------------------------------------
  // whole frame; tailEdges adds a partial byte of ones
  // ----------------------------------------
  task automatic send_frame(input logic [7:0] op, input logic [23:0] addr, input bit withAddr,
                            input int lanes, input int nBytes, input logic [7:0] base,
                            input int tailEdges);
    logic [7:0] b;
    int k;
    int i;
    selectN = 1'b0;
    for (i = 7; i >= 0; i--) begin
      clock_bits({~ioLine[3:1], op[i]});
    end
    if (withAddr) begin
      for (i = 23; i >= 0; i--) begin
        clock_bits({~ioLine[3:1], addr[i]});
      end
    end
    for (k = 0; k < nBytes; k++) begin
      b = 8'(base + k);
      for (i = 8 - lanes; i >= 0; i -= lanes) begin
        // unused lines toggle so a stale value is never mistaken for data
        clock_bits(lanes == 1 ? {~ioLine[3:1], b[i]} : lanes == 2 ? {~ioLine[3:2], b[i+:2]} :
                   b[i+:4]);
      end
    end
    for (k = 0; k < tailEdges; k++) begin
      clock_bits({~ioLine[3:1], 1'b1});
    end
    #7.5;
    selectN = 1'b1;
    ioLine = ~ioLine;
    #100;
  endtask
endmodule
`default_nettype wire

// *** bench/tb.sv ***
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PROG = 80;

  logic clk;
  logic rst;
  logic clkEn;
  logic [3:0] areaGuard;
  logic sclk;
  logic selectN;
  logic [3:0] ioLine;
  logic write_in_progress_flag;
  logic write_latch_flag;
  logic pinsOff;
  logic rej;
  logic arrWr;
  spp_pkg::spp_arr_type arrReq;
  int errors;
  int samples_checked;
  int busyLen;
  int rejCount;
  int pinsSeen;
  int v;
  logic [7:0] seen [int];
  logic [7:0] ops [3] = '{8'h02, 8'hA2, 8'h32};
  logic [23:0] addrs [3] = '{24'h000105, 24'h00023E, 24'h000300};
  int lanes [3] = '{1, 2, 4};
  int counts [3] = '{3, 4, 66};
  logic [7:0] bases [3] = '{8'h10, 8'h40, 8'h80};

  always #2.5 clk = ~clk;

  spp_host_model host (.sclk(sclk), .selectN(selectN), .ioLine(ioLine));

  spp_page_write #(.PROG_CYCLES(PROG)) dut (
    .clk(clk), .rst(rst), .clkEn(clkEn), .sclk(sclk), .selectN(selectN), .ioLine(ioLine),
    .areaGuard(areaGuard), .writeInProgressFlag(write_in_progress_flag), .writeLatchFlag(write_latch_flag),
    .sharedPinsOff(pinsOff), .cmdRejected(rej), .arrayWrite(arrWr), .arrayReq(arrReq)
  );

  // ----------------------------------------
  // monitors
  // ----------------------------------------
  always @(posedge clk) begin
    if (arrWr === 1'b1) seen[int'(arrReq.addr)] = arrReq.data;
    if (write_in_progress_flag === 1'b1) busyLen++;
    if (rej === 1'b1) rejCount++;
  end

  always @(posedge sclk) begin
    if (pinsOff === 1'b1) pinsSeen++;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic clear_marks;
    seen.delete();
    busyLen = 0;
    rejCount = 0;
    pinsSeen = 0;
  endtask

  task automatic settle;
    repeat (20) @(negedge clk);
  endtask

  task automatic wait_done;
    int t;
    t = 0;
    settle;
    while (write_in_progress_flag === 1'b1 && t < 500) begin
      @(negedge clk);
      t++;
    end
  endtask

  task automatic arm;
    host.send_frame(8'h06, 24'h0, 0, 1, 0, 8'h00, 0);
    settle;
    check_val("latch set", 1, write_latch_flag);
  endtask

  // expected page image worked out from the wrap and last-64 behaviour
  task automatic expect_page(input logic [23:0] a, input int n, input logic [7:0] base);
    logic [7:0] exp [int];
    int k;
    int slot;
    for (k = 0; k < n; k++) begin
      slot = (int'(a[5:0]) + k) % 64;
      exp[int'({a[23:6], slot[5:0]})] = 8'(base + k);
    end
    check_val("write count", exp.size(), seen.size());
    foreach (exp[j]) check_val("byte", exp[j], seen.exists(j) ? 32'(seen[j]) : 32'hFFFF_FFFF);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    clkEn = 1'b1;
    areaGuard = 4'h0;
    errors = 0;
    samples_checked = 0;
    clear_marks;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    check_val("idle progress", 0, write_in_progress_flag);
    check_val("idle latch", 0, write_latch_flag);
    host.send_frame(8'h02, 24'h000100, 1, 1, 4, 8'h10, 0);
    settle;
    check_val("unarmed writes", 0, seen.size());
    check_val("unarmed progress", 0, busyLen);
    for (v = 0; v < 3; v++) begin
      clear_marks;
      arm;
      host.send_frame(ops[v], addrs[v], 1, lanes[v], counts[v], bases[v], 0);
      check_val("progress started", 1, write_in_progress_flag);
      check_val("latch cleared", 0, write_latch_flag);
      // one foreign frame while busy: arm is dropped, status read is not
      host.send_frame(v == 1 ? 8'h05 : 8'h06, 24'h0, 0, 1, 0, 8'h00, 0);
      wait_done;
      check_val("program length", PROG, busyLen);
      check_val("busy reject", v == 1 ? 0 : 1, rejCount);
      check_val("latch after busy", 0, write_latch_flag);
      expect_page(addrs[v], counts[v], bases[v]);
    end
    check_val("shared pins off", 1, pinsSeen != 0);
    clear_marks;
    arm;
    host.send_frame(8'h02, 24'h000400, 1, 1, 2, 8'h20, 3);
    settle;
    check_val("partial byte writes", 0, seen.size());
    check_val("partial byte progress", 0, busyLen);
    check_val("shared pins one-line", 0, pinsSeen);
    areaGuard = 4'h1;
    host.send_frame(8'h02, 24'hFFC040, 1, 1, 2, 8'h30, 0);
    settle;
    check_val("guarded writes", 0, seen.size());
    check_val("guarded latch kept", 1, write_latch_flag);
    host.send_frame(8'h02, 24'hFFBFC0, 1, 1, 2, 8'h30, 0);
    // a low enable must stretch the busy time by exactly the frozen cycles
    @(negedge clk);
    clkEn = 1'b0;
    repeat (10) @(negedge clk);
    clkEn = 1'b1;
    wait_done;
    check_val("frozen length", PROG + 10, busyLen);
    expect_page(24'hFFBFC0, 2, 8'h30);
    complete_run;
  end

  initial begin
    #200us;
    errors++;
    $display("[FAIL] watchdog expected done seen hang");
    complete_run;
  end
endmodule
`default_nettype wire
